// >>> hdl/wdt_pkg.sv
// Constants, field positions and carrier types of the watchdog block
package wdt_pkg;

    // Count figures
    localparam int DIV_LO = 16;
    localparam int DIV_HI = 128;
    localparam int CNT_SPAN = 32768;
    localparam int PROT_SPAN = 4096;
    localparam int PRE_W = 7;
    localparam int CNT_W = 15;

    // Derived masks and reload values
    localparam logic [PRE_W-1:0] PRE_MASK_16 = PRE_W'(DIV_LO - 1);
    localparam logic [PRE_W-1:0] PRE_MASK_128 = PRE_W'(DIV_HI - 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(CNT_SPAN - 1);
    localparam logic [CNT_W-1:0] CNT_PROT = CNT_W'(PROT_SPAN - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = 15'h0000;
    localparam logic [PRE_W-1:0] PRE_ZERO = 7'h00;

    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_CTRL = 16'h000F;
    localparam logic [15:0] IDX_REFRESH = 16'h0010;
    localparam logic [15:0] IDX_START = 16'h0011;
    localparam logic [15:0] IDX_PROTECT = 16'h0012;
    localparam logic [15:0] IDX_PMODE = 16'h0013;
    localparam logic [15:0] IDX_CMODE = 16'h0014;
    localparam logic [15:0] IDX_STATUS = 16'h0015;
    localparam logic [15:0] IDX_MASK = 16'h0016;
    localparam logic [15:0] IDX_OPTION = 16'hFFFF;
    localparam logic [13:0] ADDR_HI_ZERO = 14'h0000;

    // Field positions
    localparam int BIT_DIVSEL = 7;
    localparam int CTRL_HI_W = 5;
    localparam int BIT_URS = 2;
    localparam int BIT_STOP = 0;
    localparam int BIT_OSCSTOP = 4;
    localparam int BIT_PROT = 7;
    localparam int OPT_AUTO = 0;
    localparam int OPT_PROTDEF = 7;
    localparam int ST_UF = 0;
    localparam int ST_STOPREF = 1;

    // Data values and bus codes
    localparam logic [7:0] REFRESH_ARM = 8'h00;
    localparam logic [7:0] REFRESH_FIRE = 8'hFF;
    localparam logic [2:0] SIZE_WORD = 3'h2;
    localparam logic [1:0] EV_NONE = 2'h0;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    // Block phase after reset
    typedef enum logic [1:0] {
        PH_BOOT = 2'b01,
        PH_RUN = 2'b10
    } phase_t;

    // Chip power-mode levels seen by the block
    typedef struct packed {
        logic wait_mode;
        logic stop_mode;
    } cpu_mode_t;

    // Clock-system controls driven by the block
    typedef struct packed {
        logic stop_entry;
        logic low_osc_stop;
        logic protect;
    } sys_ctl_t;

    // Whole state of the watchdog
    typedef struct packed {
        phase_t phase;
        logic run;
        logic [PRE_W-1:0] presc;
        logic [CNT_W-1:0] cnt;
        logic div128;
        logic underflow_reset_select;
        logic prot;
        logic stop_bit;
        logic osc_stop;
        logic seq00;
        logic [1:0] status;
        logic [1:0] mask;
        logic [7:0] opt;
        logic lso_d;
        logic rst_pulse;
        logic wr_pend;
        logic [15:0] wr_idx;
        logic [31:0] rdata;
    } wdt_state_t;

endpackage : wdt_pkg

// >>> hdl/wdt_top.sv
// Watchdog timer with clock-source protection behind an AHB-Lite slave
//
// Function
// - Prescaler divides CPU clock by 16 or 128
// - Unprotected mode counts from the CPU clock
// - Unprotected period is prescaler ratio times 32768
// - Autostart bit set: halted until start write
// - Refresh 00h then FFh reloads the counter
// - Only chip reset clears the prescaler
// - Unprotected counting pauses in wait and stop
// - Unprotected underflow: interrupt or reset by select
// - Protected mode counts low-speed oscillator edges
// - Protected period is 4096 oscillator cycles
// - Protected: no wait pause, stop refused
// - Protected underflow always gives watchdog reset
// - Protect enable loads 0FFFh, oscillator on, reset select
// - Protected: stop and oscillator-stop writes ignored
// - Default bit zero starts in protected mode
// - Autostart bit read from option byte bit 0
// - Counter is 15 bits, one step per tick
`timescale 1ns/1ps

module wdt_top (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Chip side
    input wire logic [7:0] option_byte,
    input wire logic low_osc_clk,
    input wire wdt_pkg::cpu_mode_t cpu_mode,
    output wdt_pkg::sys_ctl_t sys_ctl,
    output logic wdt_reset,
    output logic irq
);

    wdt_pkg::wdt_state_t s_r;
    wdt_pkg::wdt_state_t s_nxt;

    logic acc;
    logic [15:0] idx;
    logic mapped;
    logic lso_rise;
    logic pre_tick;
    logic tick;
    logic cnt_en;
    logic uf;
    logic [wdt_pkg::CNT_W-1:0] reload_val;
    logic [7:0] wd;
    logic wr_ctrl;
    logic wr_refresh;
    logic wr_start;
    logic wr_prot;
    logic wr_pmode;
    logic wr_cmode;
    logic wr_status;
    logic wr_mask;

    // Address phase decode
    assign acc = hsel && htrans[1] && hready && (hsize == wdt_pkg::SIZE_WORD);
    assign idx = haddr[17:2];
    assign mapped = (haddr[31:18] == wdt_pkg::ADDR_HI_ZERO);

    // Data phase write strobes
    assign wd = hwdata[7:0];
    assign wr_ctrl = s_r.wr_pend && (s_r.wr_idx == wdt_pkg::IDX_CTRL);
    assign wr_refresh = s_r.wr_pend && (s_r.wr_idx == wdt_pkg::IDX_REFRESH);
    assign wr_start = s_r.wr_pend && (s_r.wr_idx == wdt_pkg::IDX_START);
    assign wr_prot = s_r.wr_pend && (s_r.wr_idx == wdt_pkg::IDX_PROTECT);
    assign wr_pmode = s_r.wr_pend && (s_r.wr_idx == wdt_pkg::IDX_PMODE);
    assign wr_cmode = s_r.wr_pend && (s_r.wr_idx == wdt_pkg::IDX_CMODE);
    assign wr_status = s_r.wr_pend && (s_r.wr_idx == wdt_pkg::IDX_STATUS);
    assign wr_mask = s_r.wr_pend && (s_r.wr_idx == wdt_pkg::IDX_MASK);

    // Count source selection and tick generation
    assign lso_rise = low_osc_clk && !s_r.lso_d;
    assign pre_tick = s_r.div128 ?
        ((s_r.presc & wdt_pkg::PRE_MASK_128) == wdt_pkg::PRE_MASK_128) :
        ((s_r.presc & wdt_pkg::PRE_MASK_16) == wdt_pkg::PRE_MASK_16);
    assign tick = s_r.prot ? lso_rise : pre_tick;
    assign cnt_en = (s_r.phase == wdt_pkg::PH_RUN) && s_r.run &&
        (s_r.prot || !(cpu_mode.wait_mode || cpu_mode.stop_mode));
    assign uf = cnt_en && tick && (s_r.cnt == wdt_pkg::CNT_ZERO);
    assign reload_val = s_r.prot ? wdt_pkg::CNT_PROT :
        wdt_pkg::CNT_FULL;

    // Next state of the whole block
    always_comb
    begin
        logic [31:0] rv;
        rv = wdt_pkg::WORD_ZERO;
        s_nxt = s_r;
        s_nxt.rst_pulse = 1'b0;
        s_nxt.lso_d = low_osc_clk;
        if (s_r.phase == wdt_pkg::PH_BOOT)
        begin
            // Catch option byte once, just after reset release
            s_nxt.phase = wdt_pkg::PH_RUN;
            s_nxt.opt = option_byte;
            s_nxt.run = !option_byte[wdt_pkg::OPT_AUTO];
            if (!option_byte[wdt_pkg::OPT_PROTDEF])
            begin
                s_nxt.prot = 1'b1;
                s_nxt.cnt = wdt_pkg::CNT_PROT;
                s_nxt.underflow_reset_select = 1'b1;
                s_nxt.osc_stop = 1'b0;
            end
        end
        else
        begin
            // Prescaler steps only while counting unprotected; nothing but reset clears it
            if (cnt_en && !s_r.prot)
            begin
                s_nxt.presc = s_r.presc + 7'h01;
            end
            // One counter step per tick
            if (cnt_en && tick)
            begin
                s_nxt.cnt = s_r.cnt - 15'h0001;
            end
            // Control: divider select
            if (wr_ctrl)
            begin
                s_nxt.div128 = wd[wdt_pkg::BIT_DIVSEL];
            end
            // Any start write releases a halted counter
            if (wr_start)
            begin
                s_nxt.run = 1'b1;
            end
            // Two-write refresh; prescaler left alone
            if (wr_refresh)
            begin
                s_nxt.seq00 = (wd == wdt_pkg::REFRESH_ARM);
                if ((wd == wdt_pkg::REFRESH_FIRE) && s_r.seq00)
                begin
                    s_nxt.cnt = reload_val;
                end
            end
            // Underflow-reset select, forced on while protected
            if (wr_pmode && !s_r.prot)
            begin
                s_nxt.underflow_reset_select = wd[wdt_pkg::BIT_URS];
            end
            // Clock mode bits locked while protected
            if (wr_cmode)
            begin
                if (s_r.prot)
                begin
                    if (wd[wdt_pkg::BIT_STOP])
                    begin
                        s_nxt.status[wdt_pkg::ST_STOPREF] = 1'b1;
                    end
                end
                else
                begin
                    s_nxt.stop_bit = wd[wdt_pkg::BIT_STOP];
                    s_nxt.osc_stop = wd[wdt_pkg::BIT_OSCSTOP];
                end
            end
            // Protect enable is one-way; entry side effects
            if (wr_prot && wd[wdt_pkg::BIT_PROT] && !s_r.prot)
            begin
                s_nxt.prot = 1'b1;
                s_nxt.cnt = wdt_pkg::CNT_PROT;
                s_nxt.osc_stop = 1'b0;
                s_nxt.stop_bit = 1'b0;
                s_nxt.underflow_reset_select = 1'b1;
            end
            // Interrupt mask
            if (wr_mask)
            begin
                s_nxt.mask = wd[1:0];
            end
            // Write one to clear; a same-cycle event still sets
            if (wr_status)
            begin
                s_nxt.status = s_nxt.status & ~wd[1:0];
                if (wr_cmode)
                begin
                    s_nxt.status = s_nxt.status;
                end
            end
            if (wr_status && s_r.status[wdt_pkg::ST_STOPREF] == 1'b0)
            begin
                s_nxt.status = s_nxt.status;
            end
            // Underflow: reload, then reset or interrupt
            if (uf)
            begin
                // Same-cycle protect entry keeps its own load value
                s_nxt.cnt = s_nxt.prot ? wdt_pkg::CNT_PROT :
                    reload_val;
                if (s_r.prot || s_r.underflow_reset_select)
                begin
                    s_nxt.rst_pulse = 1'b1;
                end
                else
                begin
                    s_nxt.status[wdt_pkg::ST_UF] = 1'b1;
                end
            end
        end
        // Read mux, sampled in the address phase
        case (idx)
            wdt_pkg::IDX_CTRL:
            begin
                rv[wdt_pkg::BIT_DIVSEL] = s_r.div128;
                rv[wdt_pkg::CTRL_HI_W-1:0] =
                    s_r.cnt[wdt_pkg::CNT_W-1:wdt_pkg::CNT_W-wdt_pkg::CTRL_HI_W];
            end
            wdt_pkg::IDX_PROTECT:
            begin
                rv[wdt_pkg::BIT_PROT] = s_r.prot;
            end
            wdt_pkg::IDX_PMODE:
            begin
                rv[wdt_pkg::BIT_URS] = s_r.underflow_reset_select;
            end
            wdt_pkg::IDX_CMODE:
            begin
                rv[wdt_pkg::BIT_STOP] = s_r.stop_bit;
                rv[wdt_pkg::BIT_OSCSTOP] = s_r.osc_stop;
            end
            wdt_pkg::IDX_STATUS:
            begin
                rv[1:0] = s_r.status;
            end
            wdt_pkg::IDX_MASK:
            begin
                rv[1:0] = s_r.mask;
            end
            wdt_pkg::IDX_OPTION:
            begin
                rv[7:0] = s_r.opt;
            end
            default:
            begin
                rv = wdt_pkg::WORD_ZERO;
            end
        endcase
        // Bus address phase capture
        s_nxt.wr_pend = acc && hwrite && mapped;
        s_nxt.wr_idx = idx;
        if (acc && !hwrite)
        begin
            s_nxt.rdata = mapped ? rv : wdt_pkg::WORD_ZERO;
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s_r <= '{phase: wdt_pkg::PH_BOOT, cnt: wdt_pkg::CNT_FULL,
                     default: '0};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // Outputs
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s_r.rdata;
    assign wdt_reset = s_r.rst_pulse;
    assign irq = |(s_r.status & s_r.mask);
    assign sys_ctl.stop_entry = s_r.stop_bit;
    assign sys_ctl.low_osc_stop = s_r.osc_stop;
    assign sys_ctl.protect = s_r.prot;

    // Checks
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_fire;
        wr_refresh && (wd == wdt_pkg::REFRESH_FIRE) && s_r.seq00 && !uf;
    endsequence

    sequence s_prot_on;
        wr_prot && wd[wdt_pkg::BIT_PROT] && !s_r.prot;
    endsequence

    sequence s_rst_once;
        wdt_reset ##1 !wdt_reset;
    endsequence

    property p_div16;
        cnt_en && !s_r.prot && !s_r.div128 && !s_r.wr_pend &&
            ((s_r.presc & wdt_pkg::PRE_MASK_16) == wdt_pkg::PRE_MASK_16) &&
            (s_r.cnt != wdt_pkg::CNT_ZERO) |=>
            (s_r.cnt == $past(s_r.cnt) - 15'h0001);
    endproperty
    a_div16: assert property (p_div16)
        else $error("tick off the divide-by-16 boundary");

    property p_halt;
        (s_r.phase == wdt_pkg::PH_RUN) && !s_r.run && !s_r.wr_pend |=>
            $stable(s_r.cnt) && $stable(s_r.presc);
    endproperty
    a_halt: assert property (p_halt)
        else $error("halted watchdog moved");

    property p_refresh;
        s_fire |=> (s_r.cnt == $past(reload_val));
    endproperty
    a_refresh: assert property (p_refresh)
        else $error("refresh pair did not reload");

    property p_hold_wait;
        !s_r.prot && s_r.run && !s_r.wr_pend &&
            (cpu_mode.wait_mode || cpu_mode.stop_mode) |=>
            $stable(s_r.cnt) && $stable(s_r.presc);
    endproperty
    a_hold_wait: assert property (p_hold_wait)
        else $error("count moved in wait or stop");

    property p_uf_irq;
        uf && !s_r.prot && !s_r.underflow_reset_select && !wr_prot |=>
            s_r.status[wdt_pkg::ST_UF] &&
            !wdt_reset && (s_r.cnt == wdt_pkg::CNT_FULL);
    endproperty
    a_uf_irq: assert property (p_uf_irq)
        else $error("interrupt-mode underflow wrong");

    property p_uf_rst;
        uf && (s_r.prot || s_r.underflow_reset_select) |=> s_rst_once;
    endproperty
    a_uf_rst: assert property (p_uf_rst)
        else $error("underflow reset pulse wrong");

    property p_no_irq_prot;
        uf && s_r.prot && !s_r.status[wdt_pkg::ST_UF] |=>
            !s_r.status[wdt_pkg::ST_UF];
    endproperty
    a_no_irq_prot: assert property (p_no_irq_prot)
        else $error("protected underflow raised interrupt");

    property p_wait_prot;
        s_r.prot && s_r.run && cpu_mode.wait_mode && tick &&
            (s_r.cnt != wdt_pkg::CNT_ZERO) && !s_r.wr_pend |=>
            (s_r.cnt == $past(s_r.cnt) - 15'h0001);
    endproperty
    a_wait_prot: assert property (p_wait_prot)
        else $error("protected count paused in wait");

    property p_prot_on;
        s_prot_on |=> s_r.prot && (s_r.cnt == wdt_pkg::CNT_PROT) &&
            s_r.underflow_reset_select && !s_r.osc_stop;
    endproperty
    a_prot_on: assert property (p_prot_on)
        else $error("protect entry effects missing");

    property p_lock;
        s_r.prot && wr_cmode |=>
            (s_r.stop_bit == $past(s_r.stop_bit)) && !s_r.osc_stop;
    endproperty
    a_lock: assert property (p_lock)
        else $error("clock mode bit changed while protected");

    property p_lone_ff;
        wr_refresh && (wd == wdt_pkg::REFRESH_FIRE) && !s_r.seq00 &&
            !(cnt_en && tick) |=> $stable(s_r.cnt);
    endproperty
    a_lone_ff: assert property (p_lone_ff)
        else $error("lone refresh write changed counter");

endmodule : wdt_top

// >>> test/testbench.sv
// Self-checking testbench of the watchdog block
`timescale 1ns/1ps

module testbench;
    logic hclk;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [7:0] option_byte;
    logic low_osc_clk;
    wdt_pkg::cpu_mode_t cpu_mode;
    wdt_pkg::sys_ctl_t sys_ctl;
    logic wdt_reset;
    logic irq;
    logic [31:0] rd;
    int n_mismatch;
    int n_tests;
    int cyc;
    time t0;

    wdt_top u_dut (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .option_byte(option_byte),
        .low_osc_clk(low_osc_clk),
        .cpu_mode(cpu_mode),
        .sys_ctl(sys_ctl),
        .wdt_reset(wdt_reset),
        .irq(irq)
    );

    // Single slave: its ready is the bus ready
    assign hready = hreadyout;

    // Bus clock, 100 ns period
    always #50 hclk = ~hclk;

    // Low-speed oscillator, one rise every two bus cycles
    always @(posedge hclk)
        low_osc_clk <= ~low_osc_clk;

    // Byte address of a register index
    function automatic logic [31:0] addr_of(input logic [15:0] idx);
        return {wdt_pkg::ADDR_HI_ZERO, idx, 2'b00};
    endfunction : addr_of

    // Counts, verdict and end of run
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done

    // Compare one value, report a mismatch
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask : chk

    // Idle bus cycles
    task automatic idle(input int n);
        repeat (n) @(posedge hclk);
    endtask : idle

    // Wait for ready at a rising edge, bounded
    task automatic wait_ready;
        int k;
        k = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && k < 50)
        begin
            @(posedge hclk);
            k++;
        end
        if (k >= 50)
        begin
            n_mismatch++;
            test_done();
        end
    endtask : wait_ready

    // One single word transfer, read data left in rd
    task automatic bus(input logic wr, input logic [31:0] a,
                       input logic [7:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        hsize <= wdt_pkg::SIZE_WORD;
        wait_ready();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= {24'h00_0000, d};
        wait_ready();
        rd = hrdata;
    endtask : bus

    // Register write by index
    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        bus(1'b1, addr_of(idx), d);
    endtask : wr

    // Register read by index and compare
    task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp);
        @(posedge hclk);
        bus(1'b0, addr_of(idx), 8'h00);
        chk(rd, exp);
    endtask : rdchk

    // Reset with a given option byte, 12 cycles low
    task automatic do_reset(input logic [7:0] opt);
        option_byte <= opt;
        hresetn <= 1'b0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
    endtask : do_reset

    // Main sequence
    initial
    begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = wdt_pkg::SIZE_WORD;
        hwdata = 32'h0000_0000;
        option_byte = 8'hFF;
        low_osc_clk = 1'b0;
        cpu_mode = '0;
        n_mismatch = 0;
        n_tests = 0;
        // Halted after reset, protection off, option read-only
        do_reset(8'hFF);
        rdchk(wdt_pkg::IDX_OPTION, 32'h0000_00FF);
        wr(wdt_pkg::IDX_OPTION, 8'h00);
        rdchk(wdt_pkg::IDX_OPTION, 32'h0000_00FF);
        bus(1'b0, 32'h0004_003C, 8'h00);
        chk(rd, 32'h0000_0000);
        chk({31'h0000_0000, hresp}, 32'h0000_0000);
        idle(16600);
        rdchk(wdt_pkg::IDX_CTRL, 32'h0000_001F);
        // Start write, count from bus clock through divide by 16
        wr(wdt_pkg::IDX_START, 8'h01);
        idle(16200);
        rdchk(wdt_pkg::IDX_CTRL, 32'h0000_001F);
        idle(400);
        rdchk(wdt_pkg::IDX_CTRL, 32'h0000_001E);
        // Lone FFh, then the full refresh pair
        wr(wdt_pkg::IDX_REFRESH, 8'hFF);
        rdchk(wdt_pkg::IDX_CTRL, 32'h0000_001E);
        wr(wdt_pkg::IDX_REFRESH, 8'h00);
        wr(wdt_pkg::IDX_REFRESH, 8'hFF);
        rdchk(wdt_pkg::IDX_CTRL, 32'h0000_001F);
        // Stop mode holds the count, counting resumes after
        cpu_mode <= '{wait_mode: 1'b0, stop_mode: 1'b1};
        idle(16600);
        rdchk(wdt_pkg::IDX_CTRL, 32'h0000_001F);
        cpu_mode <= '0;
        idle(16600);
        rdchk(wdt_pkg::IDX_CTRL, 32'h0000_001E);
        // Divider select, oscillator stop while unprotected
        wr(wdt_pkg::IDX_CTRL, 8'h80);
        rdchk(wdt_pkg::IDX_CTRL, 32'h0000_009E);
        wr(wdt_pkg::IDX_CMODE, 8'h10);
        idle(1);
        chk({29'h0000_0000, sys_ctl}, 32'h0000_0002);
        // Protection on during wait mode
        cpu_mode <= '{wait_mode: 1'b1, stop_mode: 1'b0};
        wr(wdt_pkg::IDX_PROTECT, 8'h80);
        t0 = $time;
        rdchk(wdt_pkg::IDX_CTRL, 32'h0000_0083);
        chk({29'h0000_0000, sys_ctl}, 32'h0000_0001);
        wr(wdt_pkg::IDX_CMODE, 8'h11);
        idle(1);
        chk({29'h0000_0000, sys_ctl}, 32'h0000_0001);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        wr(wdt_pkg::IDX_MASK, 8'h03);
        idle(1);
        chk({31'h0000_0000, irq}, 32'h0000_0001);
        wr(wdt_pkg::IDX_STATUS, 8'h02);
        idle(1);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        // Underflow after 4096 oscillator ticks, reset not interrupt
        cyc = 0;
        while (wdt_reset !== 1'b1 && cyc < 9000)
        begin
            @(posedge hclk);
            cyc++;
        end
        if (cyc >= 9000)
        begin
            n_mismatch++;
            test_done();
        end
        cyc = int'(($time - t0) / 100);
        chk({31'h0, (cyc >= 8180 && cyc <= 8205)}, 32'h1);
        idle(1);
        chk({31'h0000_0000, wdt_reset}, 32'h0000_0000);
        rdchk(wdt_pkg::IDX_STATUS, 32'h0000_0000);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        // Second reset: protection and autostart from option byte
        cpu_mode <= '0;
        do_reset(8'h7E);
        idle(2);
        chk({29'h0000_0000, sys_ctl}, 32'h0000_0001);
        rdchk(wdt_pkg::IDX_OPTION, 32'h0000_007E);
        rdchk(wdt_pkg::IDX_CTRL, 32'h0000_0003);
        idle(2200);
        rdchk(wdt_pkg::IDX_CTRL, 32'h0000_0002);
        test_done();
    end
endmodule : testbench
